/* design/gpb_pkg.sv */
package gpb_pkg;

  // port geometry
  localparam int         PORT_W       = 8;
  localparam int         EXT_IRQ_W    = 4;
  localparam int         PROG_CLK_BIT = 6;
  localparam int         PROG_DAT_BIT = 7;

  // pins taking part in change detection
  localparam logic [7:0] CHG_MASK     = 8'hf0;

  // reset values
  localparam logic [7:0] DIR_RST      = 8'hff;
  localparam logic [7:0] LAT_RST      = 8'h00;
  localparam logic       PU_DIS_RST   = 1'b1;
  localparam logic [7:0] SYNC_RST     = 8'h00;

  // byte-wide write strobe with its data
  typedef struct packed {
    logic       en;
    logic [7:0] data;
  } gpb_wr_type;

  // single-bit write strobe with its data
  typedef struct packed {
    logic en;
    logic data;
  } gpb_bit_wr_type;

  // pad drive towards the pins
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pullup_en;
  } gpb_pad_type;

endpackage

/* design/gpb_sync.sv */
`timescale 1ns/1ps
module gpb_sync #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] stable
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] stable_ff;
  wire  [W-1:0] agree;
  wire  [W-1:0] nxt_stable;

  // a bit moves only once stages two and three agree
  assign agree      = ~(s2_ff ^ s3_ff);
  assign nxt_stable = (s3_ff & agree) | (stable_ff & ~agree);
  assign stable     = stable_ff;

  // three-stage chain, first stage read only by the second
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_ff   <= '0;
      s2_ff     <= '0;
      s3_ff     <= '0;
      stable_ff <= '0;
    end else begin
      meta_ff   <= async_in;
      s2_ff     <= meta_ff;
      s3_ff     <= s2_ff;
      stable_ff <= nxt_stable;
    end
  end

endmodule

/* design/gpb_port.sv */
`timescale 1ns/1ps
// Function
// - eight independent bidirectional port pins
// - direction one: driver off, pin input
// - direction zero: pin driven from latch
// - latch register reads back latch value
// - level read gives pins, write updates latch
// - one active-low bit enables all pull-ups
// - pull-up off on any output pin
// - pull-ups disabled after reset
// - only upper four input pins compared
// - compare pins with snapshot from last access
// - OR of mismatches sets change flag
// - change flag can wake the device
// - port access refreshes snapshot, except mem-move
// - mismatch keeps setting flag; access then clear
// - lower four pins double as external interrupts
// - pin six programming clock, seven programming data
module gpb_port #(
  parameter int W = gpb_pkg::PORT_W
) (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic [W-1:0]            pad_in,
  output gpb_pkg::gpb_pad_type         pad,
  input  wire gpb_pkg::gpb_wr_type     dir_wr,
  input  wire gpb_pkg::gpb_wr_type     latch_wr,
  input  wire gpb_pkg::gpb_wr_type     level_wr,
  input  wire logic                    level_rd,
  input  wire logic                    mem_to_mem_move_instr,
  input  wire gpb_pkg::gpb_bit_wr_type pullup_wr,
  input  wire logic                    change_irq_en,
  input  wire logic                    change_flag_clr,
  output logic [W-1:0]                 b_pin_level_reg,
  output logic [W-1:0]                 b_direction_reg,
  output logic [W-1:0]                 b_output_latch_reg,
  output logic                         pullup_disable_n,
  output logic                         change_irq_flag,
  output logic                         change_irq_req,
  output logic                         wake_req,
  output logic [3:0]                   lower_irq_pins,
  output logic                         prog_clock_pin,
  output logic                         prog_data_pin
);

  logic [W-1:0]         level_ff;
  logic [W-1:0]         dir_ff;
  logic [W-1:0]         latch_ff;
  logic [W-1:0]         snap_ff;
  logic                 pu_dis_ff;
  logic                 flag_ff;
  logic                 req_ff;
  logic                 wake_ff;
  logic [3:0]           ext_ff;
  logic                 prog_clk_ff;
  logic                 prog_dat_ff;
  gpb_pkg::gpb_pad_type pad_ff;
  wire  [W-1:0]         pin_sync;
  wire  [W-1:0]         nxt_dir;
  wire  [W-1:0]         nxt_latch;
  wire                  nxt_pu_dis;
  wire  [W-1:0]         mismatch;
  wire                  any_mismatch;
  wire                  port_access;
  wire                  snap_load;
  wire                  nxt_flag;

  // pin levels pass the three-stage synchroniser
  gpb_sync #(
    .W (W)
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (pad_in),
    .stable   (pin_sync)
  );

  // register write selection, latch register write wins a tie
  assign nxt_dir    = dir_wr.en ? dir_wr.data : dir_ff;
  assign nxt_latch  = latch_wr.en ? latch_wr.data :
                      (level_wr.en ? level_wr.data : latch_ff);
  assign nxt_pu_dis = pullup_wr.en ? pullup_wr.data : pu_dis_ff;

  // change detection on the upper input pins
  assign mismatch     = (level_ff ^ snap_ff) & dir_ff & gpb_pkg::CHG_MASK;
  assign any_mismatch = |mismatch;
  assign port_access  = level_rd | level_wr.en;
  assign snap_load    = port_access & ~mem_to_mem_move_instr;
  // set wins over a clear in the same cycle
  assign nxt_flag     = any_mismatch | (flag_ff & ~change_flag_clr);

  // control and pad registers
  always_ff @(posedge clock) begin
    if (rst) begin
      dir_ff           <= gpb_pkg::DIR_RST;
      latch_ff         <= gpb_pkg::LAT_RST;
      pu_dis_ff        <= gpb_pkg::PU_DIS_RST;
      pad_ff.out       <= gpb_pkg::LAT_RST;
      pad_ff.oe        <= ~gpb_pkg::DIR_RST;
      pad_ff.pullup_en <= '0;
    end else begin
      dir_ff           <= nxt_dir;
      latch_ff         <= nxt_latch;
      pu_dis_ff        <= nxt_pu_dis;
      pad_ff.out       <= nxt_latch;
      pad_ff.oe        <= ~nxt_dir;
      pad_ff.pullup_en <= nxt_dir & {W{~nxt_pu_dis}};
    end
  end

  // pin levels, snapshot and change flag
  always_ff @(posedge clock) begin
    if (rst) begin
      level_ff    <= gpb_pkg::SYNC_RST;
      snap_ff     <= gpb_pkg::SYNC_RST;
      flag_ff     <= 1'b0;
      req_ff      <= 1'b0;
      wake_ff     <= 1'b0;
      ext_ff      <= '0;
      prog_clk_ff <= 1'b0;
      prog_dat_ff <= 1'b0;
    end else begin
      level_ff    <= pin_sync;
      snap_ff     <= snap_load ? level_ff : snap_ff;
      flag_ff     <= nxt_flag;
      req_ff      <= nxt_flag & change_irq_en;
      wake_ff     <= nxt_flag;
      ext_ff      <= pin_sync[3:0];
      prog_clk_ff <= pin_sync[gpb_pkg::PROG_CLK_BIT];
      prog_dat_ff <= pin_sync[gpb_pkg::PROG_DAT_BIT];
    end
  end

  // outputs straight from flops
  assign pad                = pad_ff;
  assign b_pin_level_reg    = level_ff;
  assign b_direction_reg    = dir_ff;
  assign b_output_latch_reg = latch_ff;
  assign pullup_disable_n   = pu_dis_ff;
  assign change_irq_flag    = flag_ff;
  assign change_irq_req     = req_ff;
  assign wake_req           = wake_ff;
  assign lower_irq_pins     = ext_ff;
  assign prog_clock_pin     = prog_clk_ff;
  assign prog_data_pin      = prog_dat_ff;

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  chk_oe_from_dir: assert property (pad_ff.oe == ~dir_ff)
    else $error("output enable does not follow direction");
  chk_out_from_latch: assert property (latch_wr.en |=> pad_ff.out == $past(latch_wr.data))
    else $error("pad output differs from latch write");
  chk_latch_readback: assert property (latch_wr.en |=> b_output_latch_reg == $past(latch_wr.data))
    else $error("latch readback wrong");
  chk_level_write: assert property (level_wr.en && !latch_wr.en |=> latch_ff == $past(level_wr.data))
    else $error("level write did not reach latch");
  chk_pullup_shared: assert property (pad_ff.pullup_en == (dir_ff & {W{~pu_dis_ff}}))
    else $error("pull-up enables wrong");
  chk_pullup_output: assert property ((pad_ff.pullup_en & ~dir_ff) == '0)
    else $error("pull-up on an output pin");
  chk_pullup_reset: assert property (disable iff (1'b0) rst |=> pad_ff.pullup_en == '0 && pu_dis_ff)
    else $error("pull-ups on after reset");
  chk_dir_reset: assert property (disable iff (1'b0) rst |=> dir_ff == gpb_pkg::DIR_RST)
    else $error("direction not all inputs after reset");
  chk_lower_no_flag: assert property (
    !flag_ff && ((level_ff ^ snap_ff) & (dir_ff & gpb_pkg::CHG_MASK)) == '0 && !any_mismatch
    |=> !flag_ff)
    else $error("flag set without upper input mismatch");
  chk_flag_on_mismatch: assert property (any_mismatch |=> change_irq_flag && wake_req)
    else $error("mismatch did not set flag");
  chk_flag_sticky: assert property (flag_ff && !change_flag_clr |=> flag_ff)
    else $error("flag dropped without clear");
  chk_snap_refresh: assert property (snap_load |=> snap_ff == $past(level_ff))
    else $error("snapshot not refreshed on access");
  chk_move_keeps: assert property (port_access && mem_to_mem_move_instr |=> $stable(snap_ff))
    else $error("mem-move access refreshed snapshot");
  chk_req_gated: assert property (change_irq_req |-> change_irq_flag && $past(change_irq_en))
    else $error("request without enable");

  // flag, wake and request follow-through
  chk_wake_no_enable: assert property (any_mismatch && !change_irq_en |=> wake_req)
    else $error("wake missing while enable low");
  chk_req_on_flag: assert property (change_irq_flag && change_irq_en && !change_flag_clr |=> change_irq_req)
    else $error("request missing with flag and enable");
  chk_req_drop: assert property (!change_irq_en |=> !change_irq_req)
    else $error("request kept without enable");
  chk_clear_works: assert property (change_flag_clr && !any_mismatch |=> !change_irq_flag)
    else $error("clear ignored without mismatch");

  // registers hold between writes
  chk_snap_held: assert property (!port_access |=> $stable(snap_ff))
    else $error("snapshot moved without access");
  chk_latch_held: assert property (!latch_wr.en && !level_wr.en |=> $stable(latch_ff))
    else $error("latch moved without write");
  chk_dir_held: assert property (!dir_wr.en |=> $stable(dir_ff))
    else $error("direction moved without write");
  chk_pullup_write: assert property (pullup_wr.en |=> pullup_disable_n == $past(pullup_wr.data))
    else $error("pull-up control write lost");
  chk_pullup_held: assert property (!pullup_wr.en |=> $stable(pullup_disable_n))
    else $error("pull-up control moved without write");

  // pad drive and alternate pin views
  chk_out_follows: assert property (pad_ff.out == latch_ff)
    else $error("pad output differs from latch");
  chk_level_out: assert property (level_wr.en && !latch_wr.en |=> pad_ff.out == $past(level_wr.data))
    else $error("level write did not reach pad");
  chk_ext_pins: assert property (lower_irq_pins == b_pin_level_reg[3:0])
    else $error("external interrupt inputs differ from pins");
  chk_prog_pins: assert property (
    prog_clock_pin == b_pin_level_reg[gpb_pkg::PROG_CLK_BIT] &&
    prog_data_pin == b_pin_level_reg[gpb_pkg::PROG_DAT_BIT])
    else $error("programming pins differ from pins");

  cov_flag_rise: cover property ($rose(flag_ff));
  cov_clear_clean: cover property (flag_ff && change_flag_clr && !any_mismatch ##1 !flag_ff);
  cov_move_access: cover property (port_access && mem_to_mem_move_instr && any_mismatch);
  cov_req: cover property ($rose(change_irq_req));
  cov_output_excluded: cover property (((b_pin_level_reg ^ snap_ff) & ~b_direction_reg & gpb_pkg::CHG_MASK) != '0);

endmodule

/* sim/gpb_pins.sv */
`timescale 1ns/1ps
module gpb_pins (
  input  wire logic                 clock,
  input  wire gpb_pkg::gpb_pad_type pad,
  input  wire logic [7:0]           ext_en,
  input  wire logic [7:0]           ext_val,
  output logic      [7:0]           pad_in
);
  logic [7:0] float_ff = 8'h55;

  // undriven pins wander every cycle
  always_ff @(posedge clock) begin
    float_ff <= ~float_ff;
  end

  // wire level: own driver, then board device, then weak pull-up
  assign pad_in = (pad.oe & pad.out) | (~pad.oe & ext_en & ext_val)
                | (~pad.oe & ~ext_en & (pad.pullup_en | float_ff));
endmodule

/* sim/gpb_port_tb.sv */
`timescale 1ns/1ps
module gpb_port_tb;
  logic                 clock = 1'b0;
  logic                 rst;
  gpb_pkg::gpb_wr_type  dir_wr, latch_wr, level_wr;
  gpb_pkg::gpb_bit_wr_type pullup_wr;
  logic                 level_rd, mem_to_mem_move_instr, change_irq_en, change_flag_clr;
  gpb_pkg::gpb_pad_type pad;
  logic [7:0]           pad_in, ext_en, ext_val;
  logic [7:0]           b_pin_level_reg, b_direction_reg, b_output_latch_reg;
  logic                 pullup_disable_n, change_irq_flag, change_irq_req, wake_req;
  logic [3:0]           lower_irq_pins;
  logic                 prog_clock_pin, prog_data_pin;
  int                   errors = 0;
  int                   checks_done = 0;

  always #12.5 clock = ~clock;

  gpb_port gpb_port_i (.clock, .rst, .pad_in, .pad, .dir_wr, .latch_wr, .level_wr, .level_rd,
    .mem_to_mem_move_instr, .pullup_wr, .change_irq_en, .change_flag_clr, .b_pin_level_reg,
    .b_direction_reg, .b_output_latch_reg, .pullup_disable_n, .change_irq_flag, .change_irq_req,
    .wake_req, .lower_irq_pins, .prog_clock_pin, .prog_data_pin);

  gpb_pins gpb_pins_i (.clock, .pad, .ext_en, .ext_val, .pad_in);

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one access: 0 dir, 1 latch, 2 level write, 3 pull-up bit, 4 read, 5 move read, 6 clear
  task automatic op(input int k, input logic [7:0] d);
    @(posedge clock);
    case (k)
      0: dir_wr <= {1'b1, d};
      1: latch_wr <= {1'b1, d};
      2: level_wr <= {1'b1, d};
      3: pullup_wr <= {1'b1, d[0]};
      4: level_rd <= 1'b1;
      5: {level_rd, mem_to_mem_move_instr} <= 2'b11;
      default: change_flag_clr <= 1'b1;
    endcase
    @(posedge clock);
    {dir_wr.en, latch_wr.en, level_wr.en, pullup_wr.en} <= 4'h0;
    {level_rd, mem_to_mem_move_instr, change_flag_clr} <= 3'h0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // bounded wait for the change flag
  task automatic wflag();
    int i;
    for (i = 0; i < 20 && change_irq_flag !== 1'b1; i++) @(posedge clock);
    if (i == 20) begin
      errors++;
      $display("ERROR flag_wait expected 1 seen %b", change_irq_flag);
      print_verdict();
    end else begin
      #1;
    end
  endtask

  initial begin
    rst = 1'b1;
    {dir_wr, latch_wr, level_wr} = '0;
    pullup_wr = '0;
    {level_rd, mem_to_mem_move_instr, change_irq_en, change_flag_clr} = 4'h0;
    ext_en = 8'hff;
    ext_val = 8'h00;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    idle(1);
    check("dir", b_direction_reg, 8'hff);
    check("oe", pad.oe, 8'h00);
    check("pullup", pad.pullup_en, 8'h00);
    check("pu_bit", {7'h00, pullup_disable_n}, 8'h01);
    $display("test reset done");
    op(1, 8'ha5);
    op(0, 8'h0f);
    op(3, 8'h00);
    ext_val <= 8'h03;
    idle(7);
    check("latch", b_output_latch_reg, 8'ha5);
    check("out", pad.out, 8'ha5);
    check("oe", pad.oe, 8'hf0);
    check("pullup", pad.pullup_en, 8'h0f);
    check("level", b_pin_level_reg, 8'ha3);
    check("ext_irq", {4'h0, lower_irq_pins}, 8'h03);
    check("prog", {6'h00, prog_data_pin, prog_clock_pin}, 8'h02);
    check("dir", b_direction_reg, 8'h0f);
    check("pu_bit", {7'h00, pullup_disable_n}, 8'h00);
    ext_en <= 8'hf0;
    idle(7);
    check("pulled", b_pin_level_reg, 8'haf);
    op(2, 8'h3c);
    idle(1);
    check("latch", b_output_latch_reg, 8'h3c);
    $display("test drive done");
    op(3, 8'h01);
    ext_en <= 8'hff;
    ext_val <= 8'h00;
    op(0, 8'hff);
    idle(8);
    op(4, 8'h00);
    op(6, 8'h00);
    idle(2);
    check("flag", {7'h00, change_irq_flag}, 8'h00);
    ext_val <= 8'h20;
    wflag();
    check("wake", {7'h00, wake_req}, 8'h01);
    check("req", {7'h00, change_irq_req}, 8'h00);
    @(posedge clock) change_irq_en <= 1'b1;
    op(6, 8'h00);
    idle(1);
    check("req", {7'h00, change_irq_req}, 8'h01);
    check("flag", {7'h00, change_irq_flag}, 8'h01);
    op(5, 8'h00);
    op(6, 8'h00);
    idle(2);
    check("flag", {7'h00, change_irq_flag}, 8'h01);
    op(4, 8'h00);
    op(6, 8'h00);
    idle(2);
    check("flag", {7'h00, change_irq_flag}, 8'h00);
    check("req", {7'h00, change_irq_req}, 8'h00);
    $display("test change done");
    ext_val <= 8'h2f;
    idle(8);
    check("flag", {7'h00, change_irq_flag}, 8'h00);
    op(0, 8'hef);
    idle(8);
    check("oe", pad.oe, 8'h10);
    check("flag", {7'h00, change_irq_flag}, 8'h00);
    $display("test exclude done");
    print_verdict();
  end
endmodule
